// >>> core/sdd_decim.v
`timescale 1ns/1ps
`include "sdd_defs.vh"
module sdd_decim #(
  parameter NCH            = 8,
  parameter FIFO_DEPTH     = 16,
  parameter REF_SETTLE_CYC = `SDD_REF_SETTLE_CYC
) (
  input  wire                 i_core_clk,
  input  wire                 i_resetn,
  input  wire [NCH-1:0]       i_mod_bits,
  input  wire                 i_resync,
  input  wire [7:0]           i_addr,
  input  wire [31:0]          i_wdata,
  input  wire                 i_wr,
  input  wire                 i_rd,
  output reg  [31:0]          o_rdata,
  output reg                  o_modulator_clk,
  output wire [1:0]           o_power_mode_select,
  output wire                 o_clk_src_crystal,
  output wire                 o_crystal_osc_en,
  output wire [3*NCH-1:0]     o_channel_gain_select,
  output wire                 o_data_ready
);

  localparam AW  = 46;
  localparam FW  = 27;
  localparam FAW = 4;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function [4:0] osr_log2;
    input [2:0] code;
    begin
      osr_log2 = 5'd7 + {2'b00, code};
    end
  endfunction

  function [23:0] sat24;
    input [AW-1:0] v;
    begin
      if (!v[AW-1] && (|v[AW-2:23])) begin
        sat24 = 24'h7FFFFF;
      end else if (v[AW-1] && !(&v[AW-2:23])) begin
        sat24 = 24'h800000;
      end else begin
        sat24 = v[23:0];
      end
    end
  endfunction

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  reg  [31:0]      clock_cfg_r;
  reg  [31:0]      gain_config_reg_r;
  reg              ovf_r;
  wire [2:0]       oversampling_select;
  wire [NCH-1:0]   ch_en;
  wire [FW-1:0]    fifo_out;
  wire             fifo_out_valid;
  wire [FAW:0]     fifo_level;
  wire             fifo_in_ready;
  wire             rd_data_hit;
  reg              ref_ok_r;
  reg  [1:0]       conv_cnt_r;

  assign oversampling_select   = clock_cfg_r[`SDD_OSR_MSB:`SDD_OSR_LSB];
  assign ch_en                 = clock_cfg_r[`SDD_CHEN_MSB:`SDD_CHEN_LSB];
  assign o_power_mode_select   = clock_cfg_r[`SDD_PWR_MSB:`SDD_PWR_LSB];
  assign o_clk_src_crystal     = clock_cfg_r[`SDD_CLKSRC_BIT];
  assign o_crystal_osc_en      = clock_cfg_r[`SDD_XTALEN_BIT];
  assign o_channel_gain_select = gain_config_reg_r[3*NCH-1:0];
  assign o_data_ready          = fifo_out_valid;
  assign rd_data_hit           = i_rd && (i_addr == `SDD_ADDR_DATA);

  wire clock_wr = i_wr && (i_addr == `SDD_ADDR_CLOCK);
  wire gain_wr  = i_wr && (i_addr == `SDD_ADDR_GAIN);

  // per-channel restart mask: enable rising, gain change, oversampling change, resync
  reg  [NCH-1:0] restart;
  integer        k;
  always @* begin
    restart = {NCH{1'b0}};
    for (k = 0; k < NCH; k = k + 1) begin
      if (i_resync) begin
        restart[k] = 1'b1;
      end
      if (clock_wr && i_wdata[`SDD_CHEN_LSB + k] && !ch_en[k]) begin
        restart[k] = 1'b1;
      end
      if (clock_wr && (i_wdata[`SDD_OSR_MSB:`SDD_OSR_LSB] != oversampling_select)) begin
        restart[k] = 1'b1;
      end
      if (gain_wr && (i_wdata[3*k +: 3] != gain_config_reg_r[3*k +: 3])) begin
        restart[k] = 1'b1;
      end
    end
  end

  wire ovf_set;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clock_cfg_r       <= `SDD_CLOCK_RESET;
      gain_config_reg_r <= `SDD_GAIN_RESET;
      ovf_r             <= 1'b0;
    end else begin
      if (clock_wr) begin
        clock_cfg_r <= i_wdata & `SDD_CLOCK_WMASK;
      end
      if (gain_wr) begin
        gain_config_reg_r <= {8'h00, i_wdata[23:0]};
      end
      if (ovf_set) begin
        ovf_r <= 1'b1;
      end else if (i_wr && (i_addr == `SDD_ADDR_STATUS) && i_wdata[`SDD_ST_OVF_BIT]) begin
        ovf_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // register read, data one cycle after the strobe
  // ---------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else if (i_rd) begin
      case (i_addr)
        `SDD_ADDR_STATUS: o_rdata <= {19'h00000, fifo_level, 5'h00, ovf_r,
                                      (conv_cnt_r == `SDD_FAST_SAMPLES), ref_ok_r};
        `SDD_ADDR_DATA:   o_rdata <= {fifo_out_valid, 4'h0, fifo_out};
        `SDD_ADDR_CLOCK:  o_rdata <= clock_cfg_r;
        `SDD_ADDR_GAIN:   o_rdata <= gain_config_reg_r;
        default:          o_rdata <= 32'h00000000;
      endcase
    end else begin
      o_rdata <= 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // modulator clock and reference settling
  // ---------------------------------------------------------------
  reg  [15:0] ref_cnt_r;
  wire        mod_tick = o_modulator_clk;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_modulator_clk <= 1'b0;
      ref_cnt_r       <= 16'h0000;
      ref_ok_r        <= 1'b0;
    end else begin
      o_modulator_clk <= ~o_modulator_clk;
      if (!ref_ok_r) begin
        if (ref_cnt_r == REF_SETTLE_CYC[15:0] - 16'h0001) begin
          ref_ok_r <= 1'b1;
        end
        ref_cnt_r <= ref_cnt_r + 16'h0001;
      end
    end
  end

  // ---------------------------------------------------------------
  // decimation counter
  // ---------------------------------------------------------------
  reg  [13:0] dec_cnt_r;
  wire [13:0] dec_last = (14'h0001 << osr_log2(oversampling_select)) - 14'h0001;
  wire        dec_tick = mod_tick && (dec_cnt_r == dec_last);

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dec_cnt_r <= 14'h0000;
    end else if (clock_wr || i_resync) begin
      dec_cnt_r <= 14'h0000;
    end else if (mod_tick) begin
      dec_cnt_r <= dec_tick ? 14'h0000 : dec_cnt_r + 14'h0001;
    end
  end

  // ---------------------------------------------------------------
  // cascaded integrator-comb sinc filters, one per channel
  // ---------------------------------------------------------------
  reg  [AW-1:0] int1_r [0:NCH-1];
  reg  [AW-1:0] int2_r [0:NCH-1];
  reg  [AW-1:0] int3_r [0:NCH-1];
  reg  [AW-1:0] dly0_r [0:NCH-1];
  reg  [AW-1:0] dly1_r [0:NCH-1];
  reg  [AW-1:0] dly2_r [0:NCH-1];
  reg  [AW-1:0] dly3_r [0:NCH-1];
  reg  [23:0]   res_r  [0:NCH-1];
  reg  [AW-1:0] xin    [0:NCH-1];
  reg  [AW-1:0] s1     [0:NCH-1];
  reg  [AW-1:0] c1     [0:NCH-1];
  reg  [AW-1:0] c2     [0:NCH-1];
  reg  [AW-1:0] c3     [0:NCH-1];
  wire [4:0]    lg     = osr_log2(oversampling_select);
  wire [4:0]    sh3    = 5'd3 * lg - 5'd21;
  wire [4:0]    sh1    = 5'd23 - lg;
  wire          fast   = (conv_cnt_r != `SDD_FAST_SAMPLES);
  integer       c;

  always @* begin
    for (c = 0; c < NCH; c = c + 1) begin
      xin[c] = {{(AW-1){~i_mod_bits[c]}}, 1'b1};
      s1[c]  = int1_r[c] + xin[c] - dly0_r[c];
      c1[c]  = int3_r[c] - dly1_r[c];
      c2[c]  = c1[c] - dly2_r[c];
      c3[c]  = c2[c] - dly3_r[c];
    end
  end

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      for (c = 0; c < NCH; c = c + 1) begin
        int1_r[c] <= {AW{1'b0}};
        int2_r[c] <= {AW{1'b0}};
        int3_r[c] <= {AW{1'b0}};
        dly0_r[c] <= {AW{1'b0}};
        dly1_r[c] <= {AW{1'b0}};
        dly2_r[c] <= {AW{1'b0}};
        dly3_r[c] <= {AW{1'b0}};
        res_r[c]  <= 24'h000000;
      end
    end else begin
      for (c = 0; c < NCH; c = c + 1) begin
        if (restart[c]) begin
          int1_r[c] <= {AW{1'b0}};
          int2_r[c] <= {AW{1'b0}};
          int3_r[c] <= {AW{1'b0}};
          dly0_r[c] <= {AW{1'b0}};
          dly1_r[c] <= {AW{1'b0}};
          dly2_r[c] <= {AW{1'b0}};
          dly3_r[c] <= {AW{1'b0}};
        end else if (mod_tick) begin
          int1_r[c] <= int1_r[c] + xin[c];
          int2_r[c] <= int2_r[c] + int1_r[c];
          int3_r[c] <= int3_r[c] + int2_r[c];
          if (dec_tick) begin
            dly0_r[c] <= int1_r[c] + xin[c];
            dly1_r[c] <= int3_r[c];
            dly2_r[c] <= c1[c];
            dly3_r[c] <= c2[c];
            if (fast) begin
              res_r[c] <= sat24(s1[c] <<< sh1);
            end else begin
              res_r[c] <= sat24(($signed(c3[c]) <<< 2) >>> sh3);
            end
          end
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // frame sequencing and channel serializer
  // ---------------------------------------------------------------
  reg  [NCH-1:0] pend_r;
  reg            frame_r;
  reg  [2:0]     pick;
  integer        p;

  always @* begin
    pick = 3'h0;
    for (p = NCH - 1; p >= 0; p = p - 1) begin
      if (pend_r[p]) begin
        pick = p[2:0];
      end
    end
  end

  wire push_valid = |pend_r;
  wire push_done  = push_valid && fifo_in_ready;
  assign ovf_set  = frame_r && push_valid;

  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      frame_r    <= 1'b0;
      pend_r     <= {NCH{1'b0}};
      conv_cnt_r <= 2'h0;
    end else begin
      frame_r <= dec_tick && ref_ok_r;
      if (frame_r) begin
        pend_r <= ch_en;
        if (conv_cnt_r != `SDD_FAST_SAMPLES) begin
          conv_cnt_r <= conv_cnt_r + 2'h1;
        end
      end else if (push_done) begin
        pend_r[pick] <= 1'b0;
      end
    end
  end

  sdd_fifo #(
    .W  (FW),
    .D  (FIFO_DEPTH),
    .AW (FAW)
  ) u_fifo (
    .i_core_clk  (i_core_clk),
    .i_resetn    (i_resetn),
    .i_in_data   ({pick, res_r[pick]}),
    .i_in_valid  (push_valid && !frame_r),
    .o_in_ready  (fifo_in_ready),
    .o_out_data  (fifo_out),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (rd_data_hit),
    .o_level     (fifo_level)
  );

endmodule

// >>> core/sdd_defs.vh
`ifndef SDD_DEFS_VH
`define SDD_DEFS_VH

// ---------------------------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------------------------
`define SDD_ADDR_STATUS     8'h00
`define SDD_ADDR_DATA       8'h04
`define SDD_ADDR_CLOCK      8'h08
`define SDD_ADDR_GAIN       8'h0C

// ---------------------------------------------------------------
// clock configuration fields
// ---------------------------------------------------------------
`define SDD_PWR_LSB         0
`define SDD_PWR_MSB         1
`define SDD_OSR_LSB         2
`define SDD_OSR_MSB         4
`define SDD_CLKSRC_BIT      6
`define SDD_XTALEN_BIT      7
`define SDD_CHEN_LSB        8
`define SDD_CHEN_MSB        15
`define SDD_CLOCK_RESET     32'h0000FF0E
`define SDD_CLOCK_WMASK     32'h0000FFDF

// power mode codes
`define SDD_PWR_VLP         2'h0
`define SDD_PWR_LP          2'h1
`define SDD_PWR_HR          2'h2

// ---------------------------------------------------------------
// gain configuration: 3 bits per channel
// ---------------------------------------------------------------
`define SDD_GAIN_BITS       3
`define SDD_GAIN_RESET      32'h00000000

// ---------------------------------------------------------------
// status and data fields
// ---------------------------------------------------------------
`define SDD_ST_REFOK_BIT    0
`define SDD_ST_SINC3_BIT    1
`define SDD_ST_OVF_BIT      2
`define SDD_ST_LEVEL_LSB    8
`define SDD_DATA_VALID_BIT  31

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define SDD_CLK_MHZ         10
`define SDD_REF_SETTLE_NS   50000
`define SDD_REF_SETTLE_CYC  ((`SDD_REF_SETTLE_NS * `SDD_CLK_MHZ + 999) / 1000)
`define SDD_FAST_SAMPLES    2'h2

`endif

// >>> core/sdd_fifo.v
`timescale 1ns/1ps
module sdd_fifo #(
  parameter W  = 27,
  parameter D  = 16,
  parameter AW = 4
) (
  input  wire          i_core_clk,
  input  wire          i_resetn,
  input  wire [W-1:0]  i_in_data,
  input  wire          i_in_valid,
  output wire          o_in_ready,
  output wire [W-1:0]  o_out_data,
  output wire          o_out_valid,
  input  wire          i_out_ready,
  output wire [AW:0]   o_level
);

  reg  [W-1:0]  mem_r [0:D-1];
  reg  [AW-1:0] wr_ptr_r;
  reg  [AW-1:0] rd_ptr_r;
  reg  [AW:0]   count_r;
  wire          push;
  wire          pop;

  assign o_in_ready  = (count_r != D[AW:0]);
  assign o_out_valid = (count_r != {(AW+1){1'b0}});
  assign o_out_data  = mem_r[rd_ptr_r];
  assign o_level     = count_r;
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  // ---------------------------------------------------------------
  // pointers and storage
  // ---------------------------------------------------------------
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count_r  <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_r + 1'b1;
      end
      if (push & ~pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop & ~push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end

  always @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= i_in_data;
    end
  end

endmodule

// >>> sim/sdd_decim_checker.sv
`timescale 1ns/1ps
module sdd_decim_checker #(
  parameter NCH            = 8,
  parameter REF_SETTLE_CYC = 20
) (
  input logic               i_core_clk,
  input logic               i_resetn,
  input logic [NCH-1:0]     i_mod_bits,
  input logic               i_resync,
  input logic [7:0]         i_addr,
  input logic [31:0]        i_wdata,
  input logic               i_wr,
  input logic               i_rd,
  input logic [31:0]        o_rdata,
  input logic               o_modulator_clk,
  input logic [1:0]         o_power_mode_select,
  input logic               o_clk_src_crystal,
  input logic               o_crystal_osc_en,
  input logic [3*NCH-1:0]   o_channel_gain_select,
  input logic               o_data_ready
);
  int unsigned cyc_r;

  // cycles since reset release, saturating
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) cyc_r <= 0;
    else if (cyc_r < 100000) cyc_r <= cyc_r + 1;
  end

  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  AST_MODCLK_TOGGLE: assert property (cyc_r != 0 |-> o_modulator_clk != $past(o_modulator_clk))
    else $error("modulator clock did not toggle");
  AST_REF_HOLD: assert property (cyc_r < REF_SETTLE_CYC |-> !o_data_ready)
    else $error("data offered before reference settled");
  AST_STATUS_REF: assert property (i_rd && i_addr == 8'h00 && cyc_r < REF_SETTLE_CYC / 2 |=> !o_rdata[0])
    else $error("reference flagged settled too early");
  AST_GAIN_WRITE: assert property (i_wr && i_addr == 8'h0C |=> o_channel_gain_select == $past(i_wdata[3*NCH-1:0]))
    else $error("gain pins do not follow write");
  AST_GAIN_TOP_ZERO: assert property (i_rd && i_addr == 8'h0C |=> o_rdata[31:24] == 8'h00)
    else $error("gain upper bits not zero");
  AST_PWR_WRITE: assert property (i_wr && i_addr == 8'h08 |=> o_power_mode_select == $past(i_wdata[1:0]))
    else $error("power mode pins do not follow write");
  AST_SRC_WRITE: assert property (i_wr && i_addr == 8'h08 |=> {o_crystal_osc_en, o_clk_src_crystal} == $past(i_wdata[7:6]))
    else $error("clock source pins do not follow write");
  AST_OSR_READBACK: assert property (i_wr && i_addr == 8'h08 ##2 i_rd && i_addr == 8'h08 |=> o_rdata[4:2] == $past(i_wdata[4:2], 3))
    else $error("oversampling code readback wrong");
  AST_DATA_VALID: assert property (o_data_ready && i_rd && i_addr == 8'h04 |=> o_rdata[31] && o_rdata[30:27] == 4'h0)
    else $error("data word not valid while ready");
endmodule

bind sdd_decim sdd_decim_checker #(.NCH(NCH), .REF_SETTLE_CYC(REF_SETTLE_CYC)) u_chk (
  .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mod_bits(i_mod_bits), .i_resync(i_resync),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_modulator_clk(o_modulator_clk), .o_power_mode_select(o_power_mode_select),
  .o_clk_src_crystal(o_clk_src_crystal), .o_crystal_osc_en(o_crystal_osc_en),
  .o_channel_gain_select(o_channel_gain_select), .o_data_ready(o_data_ready)
);

// >>> sim/sdd_mod_src.sv
`timescale 1ns/1ps
module sdd_mod_src (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_modulator_clk,
  input  wire logic [7:0] i_pattern,
  output logic      [7:0] o_mod_bits
);
  // bits move only on master clock edges at modulator rate
  always @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) o_mod_bits <= i_pattern;
    else if (i_modulator_clk) o_mod_bits <= i_pattern;
  end
endmodule

// >>> sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic        i_core_clk = 0;
  logic        i_resetn   = 0;
  logic        i_resync   = 0;
  logic        i_wr       = 0;
  logic        i_rd       = 0;
  logic [7:0]  i_addr     = 8'h00;
  logic [31:0] i_wdata    = 32'h0;
  logic [7:0]  mask;
  logic [31:0] w;
  logic [31:0] gain;
  logic [31:0] v;
  wire  [7:0]  i_mod_bits;
  wire  [31:0] o_rdata;
  wire         o_modulator_clk;
  wire  [1:0]  o_power_mode_select;
  wire         o_clk_src_crystal;
  wire         o_crystal_osc_en;
  wire  [23:0] o_channel_gain_select;
  wire         o_data_ready;
  int          n_errors  = 0;
  int          tests_run = 0;
  int          cyc       = 0;
  int          t0;
  int          t1;
  bit   [31:0] seed      = 32'd88543;

  always #50 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) cyc <= cyc + 1;

  sdd_decim #(.REF_SETTLE_CYC(20)) u_dut (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_mod_bits(i_mod_bits), .i_resync(i_resync),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_modulator_clk(o_modulator_clk), .o_power_mode_select(o_power_mode_select),
    .o_clk_src_crystal(o_clk_src_crystal), .o_crystal_osc_en(o_crystal_osc_en),
    .o_channel_gain_select(o_channel_gain_select), .o_data_ready(o_data_ready)
  );

  sdd_mod_src u_src (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_modulator_clk(o_modulator_clk),
    .i_pattern(mask), .o_mod_bits(i_mod_bits)
  );

  function automatic bit [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr    <= 1'b0;
    #1;
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_core_clk);
    i_rd   <= 1'b0;
    #1 d = o_rdata;
  endtask

  task automatic wait_ready(output int t);
    int k;
    for (k = 0; k < 5000 && o_data_ready !== 1'b1; k++) begin
      @(posedge i_core_clk);
      #1;
    end
    if (k == 5000) begin
      n_errors++;
      $display("MISMATCH data_ready expected 1 seen timeout");
      close_out();
    end
    t = cyc;
  endtask

  // full: compare whole word, else channel index only
  task automatic drain(int n, bit full);
    logic [31:0] d;
    logic [2:0]  ch;
    for (int k = 0; k < n; k++) begin
      ch = k[2:0];
      rd(8'h04, d);
      if (full) chk("word", {1'b1, 4'h0, ch, mask[ch] ? 24'h7FFFFF : 24'h800000}, d);
      else chk("channel", {29'h0, ch}, {29'h0, d[26:24]});
    end
  endtask

  initial begin
    mask = 8'(xs());
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    rd(8'h00, w); chk("status", 32'h0, w);
    rd(8'h08, w); chk("clock", 32'h0000FF0E, w);
    rd(8'h0C, w); chk("gain", 32'h0, w);
    rd(8'h10, w); chk("unmapped", 32'h0, w);
    wr(8'h08, 32'h0000FF22);
    rd(8'h08, w); chk("clock", 32'h0000FF02, w);
    gain = xs();
    wr(8'h0C, gain);
    rd(8'h0C, w); chk("gain", {8'h0, gain[23:0]}, w);
    chk("gain_pins", {8'h0, gain[23:0]}, {8'h0, o_channel_gain_select});
    @(posedge i_core_clk) i_resync <= 1'b1;
    @(posedge i_core_clk) i_resync <= 1'b0;
    for (int f = 0; f < 6; f++) begin
      wait_ready(t0);
      drain(8, f < 2 || f > 3);
    end
    rd(8'h00, w); chk("status", 32'h00000003, w);
    // let four frames arrive unread: fifo full plus one stalled set
    repeat (1084) @(posedge i_core_clk);
    rd(8'h00, w); chk("status", 32'h00001007, w);
    drain(24, 1'b1);
    wr(8'h00, 32'h00000004);
    rd(8'h00, w); chk("status", 32'h00000003, w);
    for (int c = 0; c < 3; c++) begin
      v = {16'h0, 8'hFF, c[0], c[0], 1'b0, c[2:0], c[1:0]};
      wr(8'h08, v);
      chk("clk_pins", {28'h0, c[0], c[0], c[1:0]},
          {28'h0, o_crystal_osc_en, o_clk_src_crystal, o_power_mode_select});
      wait_ready(t0);
      drain(8, 1'b0);
      wait_ready(t1);
      drain(8, 1'b0);
      chk("period", 32'(256 << c), 32'(t1 - t0));
    end
    close_out();
  end
endmodule
